// ===== erx_mem_model.sv
// Memory side model that takes status writes late and reports their commit.
`timescale 1ns/10ps
module erx_mem_model (
    input  wire logic clk_i,    // System clock.
    input  wire logic rst_b_i,  // Reset, active low.
    input  wire logic valid_i,  // Status write offered.
    output logic      ready_o,  // Status write taken.
    output logic      commit_o  // Data and status committed.
);
    logic [1:0] wait_r;
    // Ready lags valid by a cycle and commit trails the take, so the slot is never freed early.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ready_o  <= 1'b0;
            commit_o <= 1'b0;
            wait_r   <= 2'h0;
        end else begin
            ready_o  <= valid_i && !ready_o;
            commit_o <= (wait_r == 2'h1);
            wait_r   <= (valid_i && ready_o) ? 2'h2 : wait_r - {1'b0, wait_r != 2'h0};
        end
    end
endmodule

// ===== erx_pkg.sv
// Shared constants, field layouts and carrier types of the receive status write-back block.
package erx_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Widths.
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned PTR_W   = 11;
    localparam int unsigned SIZE_W  = 11;
    localparam int unsigned BYTES_W = 12;
    localparam int unsigned LEN_W   = 16;
    localparam int unsigned INT_W   = 4;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CONTROL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DESC_LAST = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RETURN    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_HANDBACK  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_FLAGS     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_MASK      = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_DEBUG     = 8'h18;

    // Control register fields.
    localparam int unsigned CTL_ENABLE_BIT = 0;
    localparam int unsigned CTL_SRST_BIT   = 1;

    // Interrupt flag and mask fields.
    localparam int unsigned INT_OVERRUN_BIT = 0;
    localparam int unsigned INT_FAULT_BIT   = 1;
    localparam int unsigned INT_FULL_BIT    = 2;
    localparam int unsigned INT_DONE_BIT    = 3;

    // Fragment status word fields; the byte count minus one sits in the low SIZE_W bits.
    localparam int unsigned STS_SIZE_LSB  = 0;
    localparam int unsigned STS_CRC_BIT   = 23;
    localparam int unsigned STS_SYM_BIT   = 24;
    localparam int unsigned STS_LEN_BIT   = 25;
    localparam int unsigned STS_RANGE_BIT = 26;
    localparam int unsigned STS_ALIGN_BIT = 27;
    localparam int unsigned STS_OVR_BIT   = 28;
    localparam int unsigned STS_MISS_BIT  = 29;
    localparam int unsigned STS_FINAL_BIT = 30;
    localparam int unsigned STS_ERROR_BIT = 31;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [PTR_W-1:0]  DESC_LAST_RST = 11'h003;
    localparam logic [INT_W-1:0]  MASK_RST      = 4'h0;
    localparam logic [DATA_W-1:0] WORD_RST      = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Receive error report of one fragment.
    typedef struct packed {
        logic odd_nibble_flag;
        logic type_length_out_of_bounds_flag;
        logic length_mismatch_flag;
        logic bad_symbol_flag;
        logic frame_check_fail_flag;
        logic stall_overrun;
    } erx_err_s;

    // Status write request towards memory.
    typedef struct packed {
        logic [PTR_W-1:0]  index;
        logic [DATA_W-1:0] fragment_status_word;
        logic [DATA_W-1:0] address_hash_word;
    } erx_sts_s;

    // Status slot sequence.
    typedef enum logic [1:0] {
        SLOT_IDLE,
        SLOT_OFFER,
        SLOT_COMMIT
    } erx_slot_e;

endpackage

// ===== erx_status_wb.sv
// Receive DMA status write-back, hand-back pointer and interrupt flags with an AXI4-Lite slave.
`timescale 1ns/10ps

// Notes on behaviour
// [R01] Hand-back pointer advances by one, wrapping, once data and status are committed.
// [R02] With every owned descriptor consumed the hand-back pointer stays unchanged.
// [R03] Each received fragment writes its status word and hash word to the status array.
// [R04] Error flags appear only in a final fragment's status; earlier ones read zero.
// [R05] Size field holds bytes written minus one.
// [R06] Hash word is taken once per packet and repeated in every fragment status.
// [R07] A reception error drops the rest of the frame and marks the fragment final.
// [R08] Debug register shows only the latest whole frame's status.
// [R09] Summary error bit is the OR of the five receive error bits.
// [R10] Fault flag sets on receive errors, missing descriptor and nonfatal overrun.
// [R11] Fatal overrun shows only in the overflow interrupt flag.
// [R12] Software soft-resets the receive path after a fatal overrun.
// [R13] Missing next descriptor sets the missing bit, final flag and fault flag.
// [R14] A stalled data flow sets the overrun status bit and the fault flag.
// [R15] A new status while one is still pending sets the fatal overflow flag.
// [R16] Descriptor interrupt bit sets the completion flag after commit, for any fragment.
// [R17] Array full while enabled sets the array-full flag.
// [R18] Mask gates only the interrupt output; flags record regardless.
// [R19] Software reads statuses between pointers and advances the return pointer.
// [R20] Software discards a frame that ends with a missing descriptor.
// [R21] Array is full when hand-back equals return minus one; stop taking descriptors.
// [R22] Hand-back pointer wraps after the last index and clears on soft reset.
module erx_status_wb (
    input  wire logic                   CLK_I,               // System clock, 250 MHz.
    input  wire logic                   RST_B_I,             // Asynchronous reset, active low.
    input  wire logic [7:0]             S_AXI_AWADDR_I,      // Write address.
    input  wire logic                   S_AXI_AWVALID_I,     // Write address valid.
    output wire logic                   S_AXI_AWREADY_O,     // Write address ready.
    input  wire logic [31:0]            S_AXI_WDATA_I,       // Write data.
    input  wire logic [3:0]             S_AXI_WSTRB_I,       // Write byte strobes.
    input  wire logic                   S_AXI_WVALID_I,      // Write data valid.
    output wire logic                   S_AXI_WREADY_O,      // Write data ready.
    output wire logic [1:0]             S_AXI_BRESP_O,       // Write response.
    output wire logic                   S_AXI_BVALID_O,      // Write response valid.
    input  wire logic                   S_AXI_BREADY_I,      // Write response ready.
    input  wire logic [7:0]             S_AXI_ARADDR_I,      // Read address.
    input  wire logic                   S_AXI_ARVALID_I,     // Read address valid.
    output wire logic                   S_AXI_ARREADY_O,     // Read address ready.
    output wire logic [31:0]            S_AXI_RDATA_O,       // Read data.
    output wire logic [1:0]             S_AXI_RRESP_O,       // Read response.
    output wire logic                   S_AXI_RVALID_O,      // Read data valid.
    input  wire logic                   S_AXI_RREADY_I,      // Read data ready.
    input  wire logic                   FRAG_DONE_I,         // Fragment data written, pulse.
    input  wire logic [11:0]            FRAG_BYTES_I,        // Bytes written, 1 to 2048.
    input  wire logic                   FRAG_END_I,          // Fragment ends the frame.
    input  wire erx_pkg::erx_err_s      FRAG_ERR_I,          // Receive error report.
    input  wire logic                   NEXT_DESC_MISSING_I, // Next descriptor unavailable.
    input  wire logic                   DESC_IRQ_I,          // Descriptor interrupt bit.
    input  wire logic [31:0]            HASH_I,              // Packet address hash word.
    output wire logic                   DESC_AVAIL_O,        // Descriptors may be taken.
    output wire logic                   STS_VALID_O,         // Status write offered.
    output wire erx_pkg::erx_sts_s      STS_O,               // Status write payload.
    input  wire logic                   STS_READY_I,         // Status write accepted.
    input  wire logic                   COMMIT_I,            // Data and status committed.
    output wire logic                   IRQ_O                // Masked interrupt request.
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // State.
    logic                            en_r;
    logic [erx_pkg::PTR_W-1:0]       desc_last_r;
    logic [erx_pkg::PTR_W-1:0]       return_r;
    logic [erx_pkg::PTR_W-1:0]       handback_r;
    logic [erx_pkg::INT_W-1:0]       flags_r;
    logic [erx_pkg::INT_W-1:0]       mask_r;
    logic [erx_pkg::DATA_W-1:0]      debug_r;
    logic                            fatal_r;
    logic                            first_r;
    logic                            irq_r;
    logic [erx_pkg::DATA_W-1:0]      hash_r;
    logic [erx_pkg::LEN_W-1:0]       len_r;
    erx_pkg::erx_slot_e              slot_r;
    erx_pkg::erx_sts_s               sts_r;
    logic                            aw_full_r;
    logic                            w_full_r;
    logic [erx_pkg::ADDR_W-1:0]      aw_addr_r;
    logic [erx_pkg::DATA_W-1:0]      w_data_r;
    logic [3:0]                      w_strb_r;
    logic                            bvalid_r;
    logic [1:0]                      bresp_r;
    logic                            rvalid_r;
    logic [1:0]                      rresp_r;
    logic [erx_pkg::DATA_W-1:0]      rdata_r;

    // True for any mapped register offset.
    function automatic logic addr_ok(input logic [erx_pkg::ADDR_W-1:0] a);
        addr_ok = (a == erx_pkg::OFS_CONTROL) || (a == erx_pkg::OFS_DESC_LAST)
               || (a == erx_pkg::OFS_RETURN)  || (a == erx_pkg::OFS_HANDBACK)
               || (a == erx_pkg::OFS_FLAGS)   || (a == erx_pkg::OFS_MASK)
               || (a == erx_pkg::OFS_DEBUG);
    endfunction

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] m;
        m     = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        merge = (old & ~m) | (d & m);
    endfunction

    // Next index after p, wrapping after the programmed last index.
    function automatic logic [erx_pkg::PTR_W-1:0] next_idx(input logic [erx_pkg::PTR_W-1:0] p,
                                                          input logic [erx_pkg::PTR_W-1:0] l);
        next_idx = (p == l) ? '0 : erx_pkg::PTR_W'(p + 1'b1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // Bus write decode; address and data are caught separately, in either order.
    wire         wr_fire   = aw_full_r && w_full_r && !bvalid_r;
    wire         wr_ok     = addr_ok(aw_addr_r);
    wire         wr_ctl    = wr_fire && (aw_addr_r == erx_pkg::OFS_CONTROL);
    wire         wr_last   = wr_fire && (aw_addr_r == erx_pkg::OFS_DESC_LAST);
    wire         wr_ret    = wr_fire && (aw_addr_r == erx_pkg::OFS_RETURN);
    wire         wr_flags  = wr_fire && (aw_addr_r == erx_pkg::OFS_FLAGS);
    wire         wr_mask   = wr_fire && (aw_addr_r == erx_pkg::OFS_MASK);
    wire [31:0]  ctl_w     = merge({31'h0000_0000, en_r}, w_data_r, w_strb_r);
    wire         srst      = wr_ctl && ctl_w[erx_pkg::CTL_SRST_BIT];
    wire [31:0]  last_w    = merge({21'h00_0000, desc_last_r}, w_data_r, w_strb_r);
    wire [31:0]  ret_w     = merge({21'h00_0000, return_r}, w_data_r, w_strb_r);
    wire [31:0]  mask_w    = merge({28'h000_0000, mask_r}, w_data_r, w_strb_r);
    wire [31:0]  clr_w     = merge(32'h0000_0000, w_data_r, w_strb_r);
    wire [erx_pkg::INT_W-1:0] flag_clr = wr_flags ? clr_w[erx_pkg::INT_W-1:0] : '0;

    // Read mux; unmapped offsets read zero with an error response.
    wire [31:0]  rd_data =
        (S_AXI_ARADDR_I == erx_pkg::OFS_CONTROL)   ? {31'h0000_0000, en_r} :
        (S_AXI_ARADDR_I == erx_pkg::OFS_DESC_LAST) ? {21'h00_0000, desc_last_r} :
        (S_AXI_ARADDR_I == erx_pkg::OFS_RETURN)    ? {21'h00_0000, return_r} :
        (S_AXI_ARADDR_I == erx_pkg::OFS_HANDBACK)  ? {21'h00_0000, handback_r} :
        (S_AXI_ARADDR_I == erx_pkg::OFS_FLAGS)     ? {28'h000_0000, flags_r} :
        (S_AXI_ARADDR_I == erx_pkg::OFS_MASK)      ? {28'h000_0000, mask_r} :
        (S_AXI_ARADDR_I == erx_pkg::OFS_DEBUG)     ? debug_r : 32'h0000_0000;
    wire         rd_fire   = S_AXI_ARVALID_I && !rvalid_r;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Fragment intake and status word assembly.
    wire [4:0]   err5      = {FRAG_ERR_I.odd_nibble_flag, FRAG_ERR_I.type_length_out_of_bounds_flag,
                              FRAG_ERR_I.length_mismatch_flag, FRAG_ERR_I.bad_symbol_flag,
                              FRAG_ERR_I.frame_check_fail_flag};
    wire         any_err   = |err5;                                            // [R09]
    wire         stall     = FRAG_ERR_I.stall_overrun;
    wire         fault     = any_err || stall || NEXT_DESC_MISSING_I;
    // An error cuts the frame short, so this fragment becomes the final one.
    wire         final_frg = FRAG_END_I || fault;                             // [R07] [R13]
    wire         collide   = FRAG_DONE_I && (slot_r != erx_pkg::SLOT_IDLE) && !fatal_r;
    wire         take      = FRAG_DONE_I && (slot_r == erx_pkg::SLOT_IDLE) && !fatal_r;
    wire [31:0]  hash_cur  = first_r ? HASH_I : hash_r;                       // [R06]
    wire [erx_pkg::LEN_W-1:0] len_cur = (first_r ? '0 : len_r) + erx_pkg::LEN_W'(FRAG_BYTES_I);
    wire [erx_pkg::SIZE_W-1:0] size_m1 = erx_pkg::SIZE_W'(FRAG_BYTES_I - 12'h001); // [R05]
    wire [31:0]  err_word  = {any_err, 1'b1, NEXT_DESC_MISSING_I, stall, err5, 23'h00_0000};
    // Error bits only ever travel with a final fragment.
    wire [31:0]  sts_word  = (fault ? err_word : {1'b0, final_frg, 30'h0000_0000})
                           | {21'h00_0000, size_m1};                           // [R04]
    wire [31:0]  dbg_word  = {8'h00, NEXT_DESC_MISSING_I, stall, any_err, err5, len_cur}; // [R08]

    // Full test and pointer commit.
    wire         arr_full  = (next_idx(handback_r, desc_last_r) == return_r); // [R21]
    wire         commit    = (slot_r == erx_pkg::SLOT_COMMIT) && COMMIT_I;
    wire [erx_pkg::INT_W-1:0] flag_set = {commit && irq_r, en_r && arr_full,
                                          take && fault, collide};             // [R10] [R11] [R16]
    wire [erx_pkg::INT_W-1:0] flags_nxt = (flags_r & ~flag_clr) | flag_set;  // [R18]

    assign DESC_AVAIL_O    = en_r && !arr_full && !fatal_r;                   // [R21]
    assign STS_VALID_O     = (slot_r == erx_pkg::SLOT_OFFER);                 // [R03]
    assign STS_O           = sts_r;
    assign IRQ_O           = |(flags_r & mask_r);                             // [R18]
    assign S_AXI_AWREADY_O = !aw_full_r;
    assign S_AXI_WREADY_O  = !w_full_r;
    assign S_AXI_BVALID_O  = bvalid_r;
    assign S_AXI_BRESP_O   = bresp_r;
    assign S_AXI_ARREADY_O = !rvalid_r;
    assign S_AXI_RVALID_O  = rvalid_r;
    assign S_AXI_RRESP_O   = rresp_r;
    assign S_AXI_RDATA_O   = rdata_r;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Bus slave handshakes.
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= erx_pkg::WORD_RST;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= 2'h0;
            rvalid_r  <= 1'b0;
            rresp_r   <= 2'h0;
            rdata_r   <= erx_pkg::WORD_RST;
        end else begin
            if (S_AXI_AWVALID_I && !aw_full_r) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR_I;
            end else if (wr_fire) begin
                aw_full_r <= 1'b0;
            end
            if (S_AXI_WVALID_I && !w_full_r) begin
                w_full_r <= 1'b1;
                w_data_r <= S_AXI_WDATA_I;
                w_strb_r <= S_AXI_WSTRB_I;
            end else if (wr_fire) begin
                w_full_r <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_ok ? 2'h0 : 2'h2;
            end else if (S_AXI_BREADY_I) begin
                bvalid_r <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_data;
                rresp_r  <= addr_ok(S_AXI_ARADDR_I) ? 2'h0 : 2'h2;
            end else if (S_AXI_RREADY_I) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Software-owned registers and sticky flags; a hardware set beats a clear.
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            en_r        <= 1'b0;
            desc_last_r <= erx_pkg::DESC_LAST_RST;
            return_r    <= '0;
            mask_r      <= erx_pkg::MASK_RST;
            flags_r     <= '0;
        end else begin
            flags_r <= flags_nxt;                                             // [R17]
            if (wr_ctl) en_r <= ctl_w[erx_pkg::CTL_ENABLE_BIT];
            if (wr_last) desc_last_r <= last_w[erx_pkg::PTR_W-1:0];
            if (wr_mask) mask_r <= mask_w[erx_pkg::INT_W-1:0];
            if (srst) begin
                return_r <= '0;
            end else if (wr_ret) begin
                return_r <= ret_w[erx_pkg::PTR_W-1:0];
            end
        end
    end

    // Status slot: one status in flight; a second one arriving is a fatal overflow.
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            slot_r     <= erx_pkg::SLOT_IDLE;
            sts_r      <= '0;
            handback_r <= '0;
            fatal_r    <= 1'b0;
            first_r    <= 1'b1;
            irq_r      <= 1'b0;
            hash_r     <= erx_pkg::WORD_RST;
            len_r      <= '0;
            debug_r    <= erx_pkg::WORD_RST;
        end else if (srst) begin
            slot_r     <= erx_pkg::SLOT_IDLE;                                 // [R12]
            handback_r <= '0;                                                 // [R22]
            fatal_r    <= 1'b0;
            first_r    <= 1'b1;
        end else begin
            if (collide) fatal_r <= 1'b1;                                     // [R15]
            if (take) begin
                hash_r  <= hash_cur;
                len_r   <= len_cur;
                first_r <= final_frg;
                irq_r   <= DESC_IRQ_I;
                sts_r   <= '{index: handback_r, fragment_status_word: sts_word,
                             address_hash_word: hash_cur};                    // [R03] [R14]
                if (final_frg) debug_r <= dbg_word;                           // [R08]
            end
            unique case (slot_r)
                erx_pkg::SLOT_IDLE: begin
                    if (take) slot_r <= erx_pkg::SLOT_OFFER;
                end
                erx_pkg::SLOT_OFFER: begin
                    if (STS_READY_I) slot_r <= erx_pkg::SLOT_COMMIT;
                end
                erx_pkg::SLOT_COMMIT: begin
                    if (COMMIT_I) begin
                        slot_r     <= erx_pkg::SLOT_IDLE;
                        handback_r <= next_idx(handback_r, desc_last_r);     // [R01] [R02]
                    end
                end
                default: slot_r <= erx_pkg::SLOT_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    a_ptr_holds: assert property (!commit && !srst |=> $stable(handback_r)) // [R02]
        else $error("hand-back pointer moved without a commit");
    a_ptr_advance: assert property (commit && !srst |=> handback_r ==         // [R01]
        (($past(handback_r) == $past(desc_last_r)) ? '0 : $past(handback_r) + 1'b1))
        else $error("hand-back pointer did not advance by one with wrap");
    a_srst_clears: assert property (srst |=> handback_r == '0 && !fatal_r)     // [R22]
        else $error("soft reset left pointer or fatal state");
    a_summary_or: assert property (STS_VALID_O |-> sts_r.fragment_status_word[31] ==
        |sts_r.fragment_status_word[27:23])                                   // [R09]
        else $error("summary error bit differs from OR of error bits");
    a_error_final: assert property (STS_VALID_O && !sts_r.fragment_status_word[30]
        |-> sts_r.fragment_status_word[31:23] == 9'h000)                      // [R04]
        else $error("error bits in a non-final fragment");
    a_size_field: assert property (take && !srst |=> STS_VALID_O &&            // [R05]
        sts_r.fragment_status_word[10:0] == 11'($past(FRAG_BYTES_I) - 12'h001))
        else $error("size field is not bytes minus one");
    a_hash_repeat: assert property (take && !first_r && !srst |=>              // [R06]
        sts_r.address_hash_word == $past(hash_r))
        else $error("hash word changed inside a packet");
    a_missing_final: assert property (take && NEXT_DESC_MISSING_I && !srst |=> // [R13]
        sts_r.fragment_status_word[30:29] == 2'h3 && flags_r[1])
        else $error("missing descriptor not reported");
    a_fatal_flag: assert property (collide && !srst |=> flags_r[0] && fatal_r) // [R15]
        else $error("status overflow not flagged");
    a_done_flag: assert property (commit && irq_r |=> flags_r[3])              // [R16]
        else $error("completion flag not set after commit");
    a_full_flag: assert property (en_r && arr_full |=> flags_r[2])             // [R17]
        else $error("array-full flag not set");

endmodule

// ===== erx_status_wb_bench.sv
// Bench for register access, fragment hand-off and status checks of the write-back block.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module erx_status_wb_bench;
    logic CLK_I = 0, RST_B_I, S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0;
    logic S_AXI_ARVALID_I = 0, S_AXI_RREADY_I = 0, FRAG_DONE_I = 0, FRAG_END_I = 0;
    logic NEXT_DESC_MISSING_I = 0, DESC_IRQ_I = 0, STS_READY_I, COMMIT_I;
    logic [7:0] S_AXI_AWADDR_I = 0, S_AXI_ARADDR_I = 0;
    logic [31:0] S_AXI_WDATA_I = 0, HASH_I = 0, rdv;
    logic [3:0] S_AXI_WSTRB_I = 4'hF;
    logic [11:0] FRAG_BYTES_I = 0;
    logic [1:0] rsp;
    erx_pkg::erx_err_s FRAG_ERR_I = '0;
    erx_pkg::erx_sts_s STS_O, st;
    wire S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
    wire [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
    wire [31:0] S_AXI_RDATA_O;
    wire DESC_AVAIL_O, STS_VALID_O, IRQ_O;
    int bad_count = 0, checks = 0;
    erx_status_wb u_erx_status_wb (.*);
    erx_mem_model u_erx_mem_model (.clk_i(CLK_I), .rst_b_i(RST_B_I), .valid_i(STS_VALID_O),
        .ready_o(STS_READY_I), .commit_o(COMMIT_I));
    always #2 CLK_I = ~CLK_I;
    task automatic results();
        $display("Checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Write and read hold each address and data valid until its own ready is seen at an edge, and each response ready until its valid.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {S_AXI_AWADDR_I, S_AXI_WDATA_I} <= {a, d};
        {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} <= 3'h7;
        do begin
            @(posedge CLK_I);
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
        end while (!S_AXI_BVALID_O);
        S_AXI_BREADY_I <= 1'b0;
        rsp = S_AXI_BRESP_O;
    endtask
    task automatic rd(input logic [7:0] a);
        {S_AXI_ARADDR_I, S_AXI_ARVALID_I, S_AXI_RREADY_I} <= {a, 2'h3};
        do begin
            @(posedge CLK_I);
            if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
        end while (!S_AXI_RVALID_O);
        {S_AXI_RREADY_I, rdv, rsp} <= {1'b0, S_AXI_RDATA_O, S_AXI_RRESP_O};
        @(posedge CLK_I);
    endtask
    // One fragment: pulse, catch the status at its take, then wait past the commit.
    task automatic frag(input logic [11:0] b, input logic e, m, q, input logic [5:0] r,
                        input logic [31:0] h);
        {FRAG_BYTES_I, FRAG_END_I, NEXT_DESC_MISSING_I, DESC_IRQ_I} <= {b, e, m, q};
        {FRAG_ERR_I, HASH_I, FRAG_DONE_I} <= {r, h, 1'b1};
        @(posedge CLK_I);
        FRAG_DONE_I <= 1'b0;
        do @(posedge CLK_I); while (!(STS_VALID_O && STS_READY_I));
        st = STS_O;
        do @(posedge CLK_I); while (!COMMIT_I);
        @(posedge CLK_I);
    endtask
    initial begin
        #20000;
        bad_count++;
        results();
    end
    // Tests follow the receive flow from enable to fatal overflow.
    initial begin
        RST_B_I = 1'b0;
        repeat (10) @(posedge CLK_I);
        RST_B_I <= 1'b1;
        @(posedge CLK_I);
        `CHK({DESC_AVAIL_O, STS_VALID_O, IRQ_O, S_AXI_BVALID_O, S_AXI_RVALID_O}, 5'h00)
        wr(8'h00, 32'h0000_0001);
        frag(12'h008, 0, 0, 1, 6'h00, 32'hA5A5_0001);
        `CHK(st, {11'h000, 32'h0000_0007, 32'hA5A5_0001})
        frag(12'h003, 1, 0, 0, 6'h02, 32'h5A5A_0002);
        `CHK(st, {11'h001, 32'hC080_0002, 32'hA5A5_0001})
        rd(8'h0C); `CHK(rdv, 32'h0000_0002)
        rd(8'h10); `CHK(rdv, 32'h0000_000A)
        `CHK(IRQ_O, 1'b0)
        rd(8'h18); `CHK(rdv, 32'h0021_000B)
        wr(8'h14, 32'h0000_0002); `CHK({IRQ_O, rsp}, 3'h4)
        wr(8'h10, 32'h0000_000F);
        frag(12'h005, 1, 0, 0, 6'h00, 32'h0000_0C3C);
        `CHK(st, {11'h002, 32'h4000_0004, 32'h0000_0C3C})
        rd(8'h0C); `CHK(rdv, 32'h0000_0003)
        rd(8'h10); `CHK(rdv, 32'h0000_0004)
        `CHK(DESC_AVAIL_O, 1'b0)
        $display("Test basic fragments done");
        wr(8'h08, 32'h0000_0002); `CHK(DESC_AVAIL_O, 1'b1)
        frag(12'h008, 0, 0, 0, 6'h01, 32'h0000_0001);
        `CHK(st, {11'h003, 32'h5000_0007, 32'h0000_0001})
        frag(12'h008, 0, 1, 0, 6'h00, 32'h0000_0002);
        `CHK(st, {11'h000, 32'h6000_0007, 32'h0000_0002})
        `CHK(DESC_AVAIL_O, 1'b0)
        // The cut frame is thrown away whole by handing every descriptor back at once.
        wr(8'h08, 32'h0000_0001); `CHK(DESC_AVAIL_O, 1'b1)
        $display("Test overrun and missing done");
        wr(8'h00, 32'h0000_0003);
        rd(8'h0C); `CHK(rdv, 32'h0000_0000)
        wr(8'h10, 32'h0000_000F);
        // A second fragment, with the missing next descriptor input cleared, while the first status is offered is the fatal case.
        {NEXT_DESC_MISSING_I, FRAG_DONE_I} <= 2'h1;
        repeat (2) @(posedge CLK_I);
        FRAG_DONE_I <= 1'b0;
        repeat (8) @(posedge CLK_I);
        rd(8'h10); `CHK(rdv, 32'h0000_0001)
        `CHK(DESC_AVAIL_O, 1'b0)
        rd(8'h1C); `CHK({rdv, rsp}, {32'h0000_0000, 2'h2})
        wr(8'h1C, 32'hFFFF_FFFF); `CHK(rsp, 2'h2)
        $display("Test fatal and unmapped done");
        results();
    end
endmodule
